//--- design/ucr_top.sv
// Received character recognition for two UART channels, with registers.
// Assumes receivers on CORE_CLK offering one assembled character per pulse.
module ucr_top (
    input wire logic CORE_CLK,
    input wire logic RSTN,
    input wire logic [7:0] AXI_AWADDR,
    input wire logic AXI_AWVALID,
    output logic AXI_AWREADY,
    input wire logic [31:0] AXI_WDATA,
    input wire logic [3:0] AXI_WSTRB,
    input wire logic AXI_WVALID,
    output logic AXI_WREADY,
    output logic [1:0] AXI_BRESP,
    output logic AXI_BVALID,
    input wire logic AXI_BREADY,
    input wire logic [7:0] AXI_ARADDR,
    input wire logic AXI_ARVALID,
    output logic AXI_ARREADY,
    output logic [31:0] AXI_RDATA,
    output logic [1:0] AXI_RRESP,
    output logic AXI_RVALID,
    input wire logic AXI_RREADY,
    input wire logic PRESET,
    input wire logic [1:0] RX_VALID,
    input wire logic [8:0] RX_CHAR [2],
    input wire logic [1:0] RX_ERR [2],
    input wire logic [1:0] QUEUE_FULL,
    output logic [1:0] PUSH_VALID,
    output logic [8:0] PUSH_CHAR [2],
    output logic [1:0] PUSH_ERR [2],
    output logic [1:0] OVERRUN,
    output logic [1:0] TX_PAUSED,
    output logic [1:0] RX_ENABLED,
    output logic IRQ
);
    localparam int NCH = ucr_pkg::NCH;

    logic [7:0] mode_q [NCH];
    logic [7:0] resume_q [NCH];
    logic [7:0] pause_q [NCH];
    logic [7:0] addr_q [NCH];
    logic [2:0] seen_q [NCH];
    logic [1:0] int_q [NCH];
    logic [1:0] mask_q [NCH];
    logic [NCH-1:0] m_res, m_pau, m_adr, m_for;
    logic [NCH-1:0] acc, hr, hp, ha, hf, strip, pass;
    logic pre_s1_q, pre_s2_q;
    logic wr_en, wr_ok, rd_ok, gang_wr, gang_ld;
    logic [7:0] wr_addr, rd_addr;
    logic [31:0] wr_data, rd_data;
    logic [3:0] wr_strb;

    // Register hit for channel c at a given offset
    function automatic logic hit(input logic [7:0] a, input int c, input logic [7:0] off);
        return a[ucr_pkg::CH_BIT] == c[0] && {3'h0, a[4:0]} == off;
    endfunction

    function automatic logic wr_hit(input int c, input logic [7:0] off);
        return wr_en && wr_ok && wr_strb[0] && hit(wr_addr, c, off);
    endfunction

    ucr_axil #(.AW(ucr_pkg::AW)) u_axil (
        .clk(CORE_CLK),
        .rst_n(RSTN),
        .awaddr(AXI_AWADDR),
        .awvalid(AXI_AWVALID),
        .awready(AXI_AWREADY),
        .wdata(AXI_WDATA),
        .wstrb(AXI_WSTRB),
        .wvalid(AXI_WVALID),
        .wready(AXI_WREADY),
        .bresp(AXI_BRESP),
        .bvalid(AXI_BVALID),
        .bready(AXI_BREADY),
        .araddr(AXI_ARADDR),
        .arvalid(AXI_ARVALID),
        .arready(AXI_ARREADY),
        .rdata(AXI_RDATA),
        .rresp(AXI_RRESP),
        .rvalid(AXI_RVALID),
        .rready(AXI_RREADY),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_ok(wr_ok),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_ok(rd_ok)
    );

    assign wr_ok = ucr_pkg::mapped(wr_addr);
    assign rd_ok = ucr_pkg::mapped(rd_addr);

    // Gang commands live only in the channel A command register
    assign gang_wr = wr_en && wr_ok && wr_strb[1] && hit(wr_addr, 0, ucr_pkg::OFF_CMD)
        && wr_data[9:8] == ucr_pkg::CMD_GANG_WRITE;
    assign gang_ld = wr_en && wr_ok && wr_strb[1] && hit(wr_addr, 0, ucr_pkg::OFF_CMD)
        && wr_data[9:8] == ucr_pkg::CMD_GANG_LOAD;

    // Preset pin synchroniser
    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            pre_s1_q <= 1'b0;
            pre_s2_q <= 1'b0;
        end else begin
            pre_s1_q <= PRESET;
            pre_s2_q <= pre_s1_q;
        end
    end

    // Comparison characters: deliberately no reset value
    always_ff @(posedge CORE_CLK) begin
        for (int c = 0; c < NCH; c++) begin
            if (pre_s2_q) begin
                resume_q[c] <= ucr_pkg::RESUME_STD;
                pause_q[c] <= ucr_pkg::PAUSE_STD;
            end else if (gang_ld) begin
                resume_q[c] <= ucr_pkg::RESUME_STD;
                pause_q[c] <= ucr_pkg::PAUSE_STD;
            end else if (gang_wr) begin
                resume_q[c] <= wr_data[7:0];
                pause_q[c] <= wr_data[7:0];
            end else begin
                if (wr_hit(c, ucr_pkg::OFF_RESUME)) resume_q[c] <= wr_data[7:0];
                if (wr_hit(c, ucr_pkg::OFF_PAUSE)) pause_q[c] <= wr_data[7:0];
            end
            if (gang_wr) begin
                addr_q[c] <= wr_data[7:0];
            end else if (wr_hit(c, ucr_pkg::OFF_ADDR)) begin
                addr_q[c] <= wr_data[7:0];
            end
        end
    end

    // Mode and mask; reset clears recognition enable and all masks
    always_ff @(posedge CORE_CLK) begin
        for (int c = 0; c < NCH; c++) begin
            if (!RSTN) begin
                mode_q[c] <= ucr_pkg::MODE_RST;
                mask_q[c] <= ucr_pkg::MASK_RST;
            end else begin
                if (wr_hit(c, ucr_pkg::OFF_MODE)) mode_q[c] <= wr_data[7:0];
                if (wr_hit(c, ucr_pkg::OFF_MASK)) mask_q[c] <= wr_data[1:0];
            end
        end
    end

    // One comparator per channel, always running
    for (genvar g = 0; g < NCH; g++) begin : g_cmp
        ucr_match u_match (
            .chr(RX_CHAR[g]),
            .resume_chr(resume_q[g]),
            .pause_chr(pause_q[g]),
            .addr_chr(addr_q[g]),
            .flag_mode(mode_q[g][ucr_pkg::MB_FLAG]),
            .hit_resume(m_res[g]),
            .hit_pause(m_pau[g]),
            .hit_addr(m_adr[g]),
            .foreign_addr(m_for[g])
        );
    end

    // Qualify matches at the queue transfer point
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            acc[c] = RX_VALID[c] && !QUEUE_FULL[c];
            hr[c] = acc[c] && mode_q[c][ucr_pkg::MB_RECOG] && m_res[c];
            hp[c] = acc[c] && mode_q[c][ucr_pkg::MB_RECOG] && m_pau[c];
            ha[c] = acc[c] && mode_q[c][ucr_pkg::MB_RECOG] && mode_q[c][ucr_pkg::MB_MDROP] && m_adr[c];
            hf[c] = acc[c] && mode_q[c][ucr_pkg::MB_RECOG] && mode_q[c][ucr_pkg::MB_MDROP]
                && mode_q[c][ucr_pkg::MB_DOZE] && m_for[c];
            strip[c] = ((hr[c] || hp[c]) && mode_q[c][ucr_pkg::MB_STRIP_FLOW])
                || (ha[c] && mode_q[c][ucr_pkg::MB_STRIP_ADDR]);
            pass[c] = acc[c] && (!mode_q[c][ucr_pkg::MB_MDROP] || RX_ENABLED[c] || ha[c])
                && !hf[c] && !strip[c];
        end
    end

    // Push toward the receive queue, errors carried unchanged
    always_ff @(posedge CORE_CLK) begin
        for (int c = 0; c < NCH; c++) begin
            if (!RSTN) begin
                PUSH_VALID[c] <= 1'b0;
                OVERRUN[c] <= 1'b0;
                PUSH_CHAR[c] <= '0;
                PUSH_ERR[c] <= '0;
            end else begin
                PUSH_VALID[c] <= pass[c];
                OVERRUN[c] <= RX_VALID[c] && QUEUE_FULL[c];
                if (acc[c]) begin
                    PUSH_CHAR[c] <= RX_CHAR[c];
                    PUSH_ERR[c] <= RX_ERR[c];
                end
            end
        end
    end

    // Transmitter gating from recognised flow characters
    always_ff @(posedge CORE_CLK) begin
        for (int c = 0; c < NCH; c++) begin
            if (!RSTN) begin
                TX_PAUSED[c] <= 1'b0;
            end else if (mode_q[c][ucr_pkg::MB_AUTO_TX]) begin
                if (hp[c]) TX_PAUSED[c] <= 1'b1;
                else if (hr[c]) TX_PAUSED[c] <= 1'b0;
            end
        end
    end

    // Multi-drop receiver enable, set by own address and cleared by a doze
    always_ff @(posedge CORE_CLK) begin
        for (int c = 0; c < NCH; c++) begin
            if (!RSTN) begin
                RX_ENABLED[c] <= 1'b0;
            end else if (ha[c]) begin
                RX_ENABLED[c] <= 1'b1;
            end else if (hf[c]) begin
                RX_ENABLED[c] <= 1'b0;
            end
        end
    end

    // Sticky recognition and interrupt status, set beats write-one clear
    always_ff @(posedge CORE_CLK) begin
        for (int c = 0; c < NCH; c++) begin
            if (!RSTN) begin
                seen_q[c] <= '0;
                int_q[c] <= '0;
            end else begin
                seen_q[c] <= (seen_q[c] & ~(wr_hit(c, ucr_pkg::OFF_FLOW) ? wr_data[2:0] : 3'h0))
                    | {ha[c], hp[c], hr[c]};
                int_q[c] <= (int_q[c] & ~(wr_hit(c, ucr_pkg::OFF_INT) ? wr_data[1:0] : 2'h0))
                    | {ha[c], hr[c] || hp[c]};
            end
        end
    end

    // Interrupt when any unmasked status bit is set
    assign IRQ = |(int_q[0] & mask_q[0]) || |(int_q[1] & mask_q[1]);

    // Register read multiplexer
    always_comb begin
        logic ch;
        logic [7:0] off;
        ch = rd_addr[ucr_pkg::CH_BIT];
        off = {3'h0, rd_addr[4:0]};
        rd_data = 32'h0;
        case (off)
            ucr_pkg::OFF_MODE: rd_data[7:0] = mode_q[ch];
            ucr_pkg::OFF_RESUME: rd_data[7:0] = resume_q[ch];
            ucr_pkg::OFF_PAUSE: rd_data[7:0] = pause_q[ch];
            ucr_pkg::OFF_ADDR: rd_data[7:0] = addr_q[ch];
            ucr_pkg::OFF_FLOW: rd_data[4:0] = {RX_ENABLED[ch], TX_PAUSED[ch], seen_q[ch]};
            ucr_pkg::OFF_INT: rd_data[1:0] = int_q[ch];
            ucr_pkg::OFF_MASK: rd_data[1:0] = mask_q[ch];
            default: rd_data = 32'h0;
        endcase
    end

    // Checks on channel A flow control, the gang load and channel B multi-drop behaviour
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RSTN);

    property p_overrun_drop;
        RX_VALID[0] && QUEUE_FULL[0] |=> !PUSH_VALID[0] && OVERRUN[0] && !$rose(int_q[0][0]);
    endproperty
    a_overrun_drop: assert property (p_overrun_drop) else $error("full queue char pushed");

    property p_match_status;
        RX_VALID[0] && !QUEUE_FULL[0] && mode_q[0][0] && RX_CHAR[0][7:0] == resume_q[0]
            |=> seen_q[0][0] && int_q[0][0];
    endproperty
    a_match_status: assert property (p_match_status) else $error("resume match not flagged");

    property p_pause_gate;
        RX_VALID[0] && !QUEUE_FULL[0] && mode_q[0][0] && mode_q[0][1] && RX_CHAR[0][7:0] == pause_q[0]
            |=> TX_PAUSED[0];
    endproperty
    a_pause_gate: assert property (p_pause_gate) else $error("pause did not gate tx");

    property p_strip;
        (hr[0] || hp[0]) && mode_q[0][5]
            |=> !PUSH_VALID[0] && (!$past(mode_q[0][1]) || TX_PAUSED[0] == $past(hp[0]));
    endproperty
    a_strip: assert property (p_strip) else $error("stripped char pushed or not acted on");

    property p_keep_err;
        (hr[0] || hp[0]) && !mode_q[0][5] && !mode_q[0][2] |=> PUSH_VALID[0] && PUSH_ERR[0] == $past(RX_ERR[0]);
    endproperty
    a_keep_err: assert property (p_keep_err) else $error("kept char lost or errors altered");

    property p_gang_load;
        gang_ld && !pre_s2_q |=> resume_q[1] == 8'h11 && pause_q[1] == 8'h13 && resume_q[0] == 8'h11;
    endproperty
    a_gang_load: assert property (p_gang_load) else $error("gang load wrong codes");

    property p_wake;
        ha[1] |=> RX_ENABLED[1] && seen_q[1][2] && int_q[1][1];
    endproperty
    a_wake: assert property (p_wake) else $error("own address did not wake");

    property p_doze;
        hf[1] |=> !RX_ENABLED[1] && !PUSH_VALID[1];
    endproperty
    a_doze: assert property (p_doze) else $error("foreign address did not doze");

    property p_irq;
        int_q[0][0] && mask_q[0][0] |-> IRQ;
    endproperty
    a_irq: assert property (p_irq) else $error("unmasked status without irq");

    property p_disabled;
        !mode_q[0][0] |=> !$rose(int_q[0][0]) && !$rose(TX_PAUSED[0]);
    endproperty
    a_disabled: assert property (p_disabled) else $error("recognition acted while off");

    c_resume: cover property (hr[0] ##1 int_q[0][0]);
    c_wake: cover property (ha[1] ##1 RX_ENABLED[1]);
    c_gang: cover property (gang_wr ##1 addr_q[1] == resume_q[0]);
endmodule

//--- design/ucr_pkg.sv
// Constants shared by the character recognition block.
// Assumes a 32-bit AXI4-Lite register port and two receive channels.
package ucr_pkg;
    // Channel count and register address width
    localparam int NCH = 2;
    localparam int AW = 8;
    // Register offsets inside one channel window, window stride 0x20
    localparam logic [7:0] OFF_MODE = 8'h00;
    localparam logic [7:0] OFF_RESUME = 8'h04;
    localparam logic [7:0] OFF_PAUSE = 8'h08;
    localparam logic [7:0] OFF_ADDR = 8'h0c;
    localparam logic [7:0] OFF_FLOW = 8'h10;
    localparam logic [7:0] OFF_INT = 8'h14;
    localparam logic [7:0] OFF_MASK = 8'h18;
    localparam logic [7:0] OFF_CMD = 8'h1c;
    localparam int CH_BIT = 5;
    // Mode register zero fields
    localparam int MB_RECOG = 0;
    localparam int MB_AUTO_TX = 1;
    localparam int MB_MDROP = 2;
    localparam int MB_DOZE = 3;
    localparam int MB_FLAG = 4;
    localparam int MB_STRIP_FLOW = 5;
    localparam int MB_STRIP_ADDR = 6;
    // Recognition status fields (sticky part plus two live states)
    localparam int SB_RESUME = 0;
    localparam int SB_PAUSE = 1;
    localparam int SB_ADDR = 2;
    localparam int SB_TXPAUSED = 3;
    localparam int SB_RXEN = 4;
    // Interrupt status and mask fields
    localparam int IB_FLOW = 0;
    localparam int IB_ADDR = 1;
    // Values after reset
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [1:0] MASK_RST = 2'h0;
    // Standard flow codes
    localparam logic [7:0] RESUME_STD = 8'h11;
    localparam logic [7:0] PAUSE_STD = 8'h13;
    // Command field in channel A command register, bits 9:8
    localparam logic [1:0] CMD_GANG_WRITE = 2'h1;
    localparam logic [1:0] CMD_GANG_LOAD = 2'h2;
    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Aligned address inside the two channel windows
    function automatic logic mapped(input logic [AW-1:0] a);
        return a[7:6] == 2'h0 && a[1:0] == 2'h0;
    endfunction
endpackage

//--- design/ucr_match.sv
// Comparator for one channel: received character against three characters.
// Assumes a combinational caller that qualifies the result with a valid.
module ucr_match (
    input wire logic [8:0] chr,
    input wire logic [7:0] resume_chr,
    input wire logic [7:0] pause_chr,
    input wire logic [7:0] addr_chr,
    input wire logic flag_mode,
    output logic hit_resume,
    output logic hit_pause,
    output logic hit_addr,
    output logic foreign_addr
);
    logic addr_eq;

    // Plain 8-bit compares; a break's zero byte compares like any other
    assign hit_resume = chr[7:0] == resume_chr;
    assign hit_pause = chr[7:0] == pause_chr;
    assign addr_eq = chr[7:0] == addr_chr;
    // Flag mode: only characters with bit 8 set are addresses
    assign hit_addr = flag_mode ? (chr[8] && addr_eq) : addr_eq;
    assign foreign_addr = flag_mode && chr[8] && !addr_eq;
endmodule

//--- design/ucr_axil.sv
// AXI4-Lite slave front end turning bus cycles into register strobes.
// Assumes one clock and a synchronous active-low reset.
module ucr_axil #(
    parameter int AW = ucr_pkg::AW
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [AW-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [AW-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic wr_en,
    output logic [AW-1:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [3:0] wr_strb,
    input wire logic wr_ok,
    output logic [AW-1:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic rd_ok
);
    logic aw_full_q;
    logic w_full_q;

    // Each channel holds one item until the response is taken
    assign awready = !aw_full_q;
    assign wready = !w_full_q;
    assign arready = !rvalid;
    assign wr_en = aw_full_q && w_full_q && !bvalid;
    assign rd_addr = araddr;

    // Write address capture
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            aw_full_q <= 1'b0;
            wr_addr <= '0;
        end else if (awvalid && awready) begin
            aw_full_q <= 1'b1;
            wr_addr <= awaddr;
        end else if (bvalid && bready) begin
            aw_full_q <= 1'b0;
        end
    end

    // Write data capture
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            w_full_q <= 1'b0;
            wr_data <= '0;
            wr_strb <= '0;
        end else if (wvalid && wready) begin
            w_full_q <= 1'b1;
            wr_data <= wdata;
            wr_strb <= wstrb;
        end else if (bvalid && bready) begin
            w_full_q <= 1'b0;
        end
    end

    // Write response, one cycle after both halves are held
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bvalid <= 1'b0;
            bresp <= ucr_pkg::RESP_OKAY;
        end else if (wr_en) begin
            bvalid <= 1'b1;
            bresp <= wr_ok ? ucr_pkg::RESP_OKAY : ucr_pkg::RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // Read answer registered at the address handshake
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= ucr_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata <= rd_ok ? rd_data : 32'h0;
            rresp <= rd_ok ? ucr_pkg::RESP_OKAY : ucr_pkg::RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end
endmodule

//--- verif/ucr_remote_tx.sv
// Remote transmitter as seen after the receivers: assembled characters, one pulse each.
// Assumes it shares the block's clock and is called just after a rising edge.
module ucr_remote_tx (
    input wire logic clk,
    output logic [1:0] rx_valid,
    output logic [8:0] rx_char [2],
    output logic [1:0] rx_err [2]
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle lines at time zero
    initial begin
        rx_valid = 2'h0;
        rx_char[0] = 9'h000;
        rx_char[1] = 9'h000;
        rx_err[0] = 2'h0;
        rx_err[1] = 2'h0;
    end

    // One character for one edge; afterwards the lines carry junk, not the old value
    // Returns at the following rising edge, where the answer launched by the first edge is settled
    task automatic send(input int ch, input logic [8:0] c, input logic [1:0] e);
        rx_valid[ch] <= 1'b1;
        rx_char[ch] <= c;
        rx_err[ch] <= e;
        @(posedge clk);
        rx_valid[ch] <= 1'b0;
        rx_char[ch] <= ~c;
        rx_err[ch] <= ~e;
        @(posedge clk);
    endtask
endmodule

//--- verif/uart_char_recognition_tb.sv
// Self-checking bench: register tasks over AXI4-Lite plus a character source.
// Assumes the recognition top and the remote transmitter model are compiled first.
module uart_char_recognition_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rstn = 1'b0, preset = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [1:0] qfull = 2'h0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp, rxv, pushv, ovr, txp, rxen;
    logic [31:0] rdata;
    logic [8:0] rxc [2];
    logic [8:0] pushc [2];
    logic [1:0] rxe [2];
    logic [1:0] pushe [2];
    int num_errors = 0, cmp_count = 0;

    // 125 MHz clock
    always #4 clk = ~clk;

    ucr_top uut (
        .CORE_CLK(clk), .RSTN(rstn), .AXI_AWADDR(awaddr), .AXI_AWVALID(awvalid), .AXI_AWREADY(awready),
        .AXI_WDATA(wdata), .AXI_WSTRB(wstrb), .AXI_WVALID(wvalid), .AXI_WREADY(wready),
        .AXI_BRESP(bresp), .AXI_BVALID(bvalid), .AXI_BREADY(bready), .AXI_ARADDR(araddr),
        .AXI_ARVALID(arvalid), .AXI_ARREADY(arready), .AXI_RDATA(rdata), .AXI_RRESP(rresp),
        .AXI_RVALID(rvalid), .AXI_RREADY(rready), .PRESET(preset), .RX_VALID(rxv), .RX_CHAR(rxc),
        .RX_ERR(rxe), .QUEUE_FULL(qfull), .PUSH_VALID(pushv), .PUSH_CHAR(pushc), .PUSH_ERR(pushe),
        .OVERRUN(ovr), .TX_PAUSED(txp), .RX_ENABLED(rxen), .IRQ(irq)
    );

    ucr_remote_tx rtx (.clk(clk), .rx_valid(rxv), .rx_char(rxc), .rx_err(rxe));

    // Compare and count
    task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, exp, got);
        end
    endtask

    // Write one word; address and data released as each is taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        chk("bresp", 32'(bresp), 32'(er));
        // Idle edge so a following call never re-raises bready in this time step
        @(posedge clk);
    endtask

    // Read one word
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready)
                arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        d = rdata;
        r = rresp;
        // Idle edge so a following call never re-raises rready in this time step
        @(posedge clk);
    endtask

    // Read and compare data
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk($sformatf("reg %h", a), d, e);
    endtask

    // Print counts and verdict, then stop
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        finish_test();
    end

    // Test sequence
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rc(8'h00, 32'h0);
        rc(8'h18, 32'h0);
        chk("irq", 32'(irq), 32'h0);
        preset <= 1'b1;
        repeat (5) @(posedge clk);
        preset <= 1'b0;
        repeat (3) @(posedge clk);
        rc(8'h24, 32'h11);
        rc(8'h28, 32'h13);
        wr(8'h1c, 32'h15a, 2'h0);
        for (int i = 0; i < 6; i++)
            rc(8'(i / 3 * 32 + i % 3 * 4 + 4), 32'h5a);
        wr(8'h1c, 32'h200, 2'h0);
        for (int i = 0; i < 6; i++)
            rc(8'(i / 3 * 32 + i % 3 * 4 + 4), i % 3 == 0 ? 32'h11 : i % 3 == 1 ? 32'h13 : 32'h5a);
        rd(8'h40, d, r);
        chk("rdata unmapped", d, 32'h0);
        chk("rresp unmapped", 32'(r), 32'(ucr_pkg::RESP_SLVERR));
        wr(8'h44, 32'h1, ucr_pkg::RESP_SLVERR);
        // Pause on channel A with auto gating and interrupt enabled
        wr(8'h00, 32'h03, 2'h0);
        wr(8'h18, 32'h01, 2'h0);
        rtx.send(0, 9'h013, 2'h0);
        chk("push_valid", 32'(pushv), 32'h1);
        chk("push_char", 32'(pushc[0]), 32'h13);
        chk("tx_paused", 32'(txp), 32'h1);
        chk("irq", 32'(irq), 32'h1);
        rc(8'h10, 32'h0a);
        rc(8'h14, 32'h01);
        wr(8'h14, 32'h01, 2'h0);
        chk("irq", 32'(irq), 32'h0);
        wr(8'h10, 32'h02, 2'h0);
        rc(8'h10, 32'h08);
        // Stripped resume with errors still acts
        wr(8'h00, 32'h23, 2'h0);
        rtx.send(0, 9'h011, 2'h3);
        chk("push_valid", 32'(pushv), 32'h0);
        chk("tx_paused", 32'(txp), 32'h0);
        chk("irq", 32'(irq), 32'h1);
        wr(8'h00, 32'h03, 2'h0);
        rtx.send(0, 9'h013, 2'h3);
        chk("push_err", 32'(pushe[0]), 32'h3);
        chk("tx_paused", 32'(txp), 32'h1);
        // Resume arriving on a full queue
        qfull <= 2'h1;
        rtx.send(0, 9'h011, 2'h0);
        chk("overrun", 32'(ovr), 32'h1);
        chk("push_valid", 32'(pushv), 32'h0);
        chk("tx_paused", 32'(txp), 32'h1);
        qfull <= 2'h0;
        // Break character on channel B
        wr(8'h24, 32'h00, 2'h0);
        wr(8'h20, 32'h01, 2'h0);
        rtx.send(1, 9'h000, 2'h0);
        rc(8'h30, 32'h01);
        // Multi-drop wake and doze on channel B
        wr(8'h20, 32'h1d, 2'h0);
        rtx.send(1, 9'h041, 2'h0);
        chk("push_valid", 32'(pushv), 32'h0);
        rtx.send(1, 9'h15a, 2'h0);
        chk("rx_enabled", 32'(rxen), 32'h2);
        chk("push_valid", 32'(pushv), 32'h2);
        rtx.send(1, 9'h041, 2'h0);
        chk("push_valid", 32'(pushv), 32'h2);
        chk("push_char", 32'(pushc[1]), 32'h41);
        rtx.send(1, 9'h177, 2'h0);
        chk("rx_enabled", 32'(rxen), 32'h0);
        // Own value without the address flag must not wake; stripped own address still wakes
        rtx.send(1, 9'h05a, 2'h0);
        chk("rx_enabled", 32'(rxen), 32'h0);
        wr(8'h20, 32'h5d, 2'h0);
        rtx.send(1, 9'h15a, 2'h0);
        chk("push_valid", 32'(pushv), 32'h0);
        chk("rx_enabled", 32'(rxen), 32'h2);
        rc(8'h34, 32'h03);
        // Reset in mid-run turns recognition off
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        chk("tx_paused", 32'(txp), 32'h0);
        chk("irq", 32'(irq), 32'h0);
        rc(8'h00, 32'h0);
        rtx.send(0, 9'h013, 2'h0);
        chk("tx_paused", 32'(txp), 32'h0);
        finish_test();
    end
endmodule
